/* design/rlvd_pkg.sv */
`default_nettype none
package rlvd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0]  OFF_LVC  = 8'h00;
  localparam logic [7:0]  OFF_CTRL = 8'h04;
  localparam logic [7:0]  OFF_WDT  = 8'h08;
  localparam logic [7:0]  OFF_STAT = 8'h0C;

  // ----------------------------------------------------------------
  // low_voltage_control fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  LVC_RESET     = 8'h48;
  localparam int unsigned LVC_PEND      = 7;
  localparam int unsigned LVC_RST_ALLOW = 6;
  localparam int unsigned LVC_ON_N      = 5;
  localparam int unsigned LVC_GATE_N    = 4;
  localparam int unsigned LVC_PIN_N     = 3;
  localparam int unsigned LVC_SUP_N     = 2;
  localparam int unsigned LVC_LVL_LSB   = 0;

  // ----------------------------------------------------------------
  // block control, watchdog and status fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W        = 4;
  localparam logic [3:0]  CTRL_RESET    = 4'h0;
  localparam int unsigned CTRL_IRQ_EN   = 0;
  localparam int unsigned CTRL_RTC_RST  = 1;
  localparam int unsigned CTRL_WDT_EN   = 2;
  localparam int unsigned CTRL_WAKE_EN  = 3;
  localparam int unsigned WDT_KICK      = 5;
  localparam int unsigned STAT_PG       = 0;
  localparam int unsigned STAT_POR_DONE = 1;
  localparam int unsigned STAT_DET_SUP  = 2;
  localparam int unsigned STAT_DET_PIN  = 3;
  localparam int unsigned STAT_CAUSE    = 8;
  localparam int unsigned CAUSE_W       = 5;
  localparam logic [4:0]  CAUSE_RESET   = 5'h01;
  localparam int unsigned CAUSE_POR     = 0;
  localparam int unsigned CAUSE_LVD     = 1;
  localparam int unsigned CAUSE_RTC     = 2;
  localparam int unsigned CAUSE_WDT     = 3;
  localparam int unsigned CAUSE_WAKE    = 4;

  // ----------------------------------------------------------------
  // pins, thresholds, timing
  // ----------------------------------------------------------------
  localparam int unsigned PIN_W       = 4;
  localparam int unsigned PIN_PG      = 0;
  localparam int unsigned PIN_RTC_SEC = 1;
  localparam int unsigned PIN_RTC_ALM = 2;
  localparam int unsigned PIN_WAKE    = 3;
  localparam int unsigned MV_W        = 12;
  localparam logic [11:0] HYST_MV     = 12'h096;
  localparam logic [11:0] PIN_THR_MV [4] = '{12'h708, 12'h79E, 12'h898, 12'h9C4};
  localparam logic [11:0] SUP_THR_MV [4] = '{12'h898, 12'h960, 12'hA8C, 12'hC1C};
  localparam logic [15:0] RESET_VECTOR   = 16'h8000;
  localparam int unsigned CLK_FREQ_KHZ   = 10000;
  localparam int unsigned POR_DELAY_US   = 4000;
  localparam int unsigned POR_DELAY_CYC  = POR_DELAY_US * CLK_FREQ_KHZ / 1000;
  localparam int unsigned WDT_PERIOD_CYC = 65536;
  localparam int unsigned RST_HOLD_CYC   = 16;

endpackage
`default_nettype wire

/* design/rlvd_rst_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module rlvd_rst_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // reset request from this domain
  input  wire logic rst_req,
  // synchronised system reset
  output logic      sys_rst_n
);
  import rlvd_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
  } rlvd_sync_s;

  rlvd_sync_s st_r;
  rlvd_sync_s st_nxt;
  logic       clr_n;

  // request comes from a flop, so the clear path is glitch free
  assign clr_n = presetn & ~rst_req;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = 1'b1;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge pclk or negedge clr_n) begin
    if (!clr_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sys_rst_n = st_r.s2;
endmodule // rlvd_rst_sync
`default_nettype wire

/* design/rlvd_por_delay.sv */
`timescale 1ns/1ns
`default_nettype none
module rlvd_por_delay #(
  parameter int unsigned DELAY_CYC = rlvd_pkg::POR_DELAY_CYC
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // synchronised power-good level
  input  wire logic pg,
  // delay expired
  output logic      done
);
  import rlvd_pkg::*;

  localparam int unsigned CW = $clog2(DELAY_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
  } rlvd_por_s;

  rlvd_por_s st_r;
  rlvd_por_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!pg) begin
      // losing power good restarts the whole delay
      st_nxt = '0;
    end else if (!st_r.done) begin
      if (st_r.cnt == CW'(DELAY_CYC - 1)) begin
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
endmodule // rlvd_por_delay
`default_nettype wire

/* design/rlvd_top.sv */
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none

// How it works
// R1: release reset 4 ms after power good
// R2: reset spans ramp plus counter interval
// R3: OR all reset sources into one
// R4: fetch address forced to 8000h in reset
// R5: power good loss restarts full reset
// R6: four thresholds from 2-bit level field
// R7: detection interrupts if enabled, else resets
// R8: software gates output off while settling
// R9: software enable order, 30 us wait
// R10: bit 7 pending, set by hardware, write-0 clears
// R11: bit 6 allows detector reset, resets 1
// R12: bit 5 low switches detector on
// R13: bit 4 low passes detector output
// R14: bit 3 low senses pin, resets 1
// R15: bit 2 low senses regulator supply
// R16: 150 mV hysteresis on comparison
// R17: rtc events reset only when allowed
// R18: watchdog resets unless bit 5 kicked
// R19: port wakeup resets during sleep
// R20: delay count parameter from clock rate
// R21: reset asserts async, releases through synchroniser
module rlvd_top #(
  parameter int unsigned POR_CYC = rlvd_pkg::POR_DELAY_CYC,
  parameter int unsigned WDT_CYC = rlvd_pkg::WDT_PERIOD_CYC,
  parameter int unsigned HOLD_CYC = rlvd_pkg::RST_HOLD_CYC
) (
  // apb clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [rlvd_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // asynchronous pins
  input  wire logic                        power_good_level,
  input  wire logic                        rtc_second,
  input  wire logic                        rtc_alarm,
  input  wire logic                        port_wake,
  // same-clock inputs
  input  wire logic                        sleep_mode,
  input  wire logic [rlvd_pkg::MV_W-1:0]   regulator_input_supply,
  input  wire logic [rlvd_pkg::MV_W-1:0]   pin_voltage,
  // to core
  output logic                             sys_rst_n,
  output logic                             fetch_restart,
  output logic [15:0]                      fetch_addr,
  output logic                             undervolt_irq
);
  import rlvd_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int unsigned WW = $clog2(WDT_CYC + 1);
  localparam int unsigned HW = $clog2(HOLD_CYC + 1);

  typedef struct packed {
    logic [7:0]         lvc;
    logic [CTRL_W-1:0]  ctrl;
    logic [CAUSE_W-1:0] cause;
    logic [PIN_W-1:0]   s1;
    logic [PIN_W-1:0]   s2;
    logic [PIN_W-1:0]   s3;
    logic               det_sup;
    logic               det_pin;
    logic               gated_d;
    logic [WW-1:0]      wdt_cnt;
    logic [HW-1:0]      hold;
    logic               rst_req;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic               irq;
    logic               restart;
    logic [15:0]        fetch;
  } rlvd_state_s;

  // core held in reset with the vector already loaded
  localparam rlvd_state_s ST_RESET = '{
    lvc:     LVC_RESET,
    ctrl:    CTRL_RESET,
    cause:   CAUSE_RESET,
    s1:      '0,
    s2:      '0,
    s3:      '0,
    det_sup: 1'b0,
    det_pin: 1'b0,
    gated_d: 1'b0,
    wdt_cnt: '0,
    hold:    '0,
    rst_req: 1'b1,
    pready:  1'b0,
    pslverr: 1'b0,
    prdata:  '0,
    irq:     1'b0,
    restart: 1'b1,
    fetch:   RESET_VECTOR
  };

  rlvd_state_s      r;
  rlvd_state_s      n;
  logic             por_done;
  logic [PIN_W-1:0] pins;

  assign pins = {port_wake, rtc_alarm, rtc_second, power_good_level};

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  rlvd_por_delay #(
    .DELAY_CYC (POR_CYC)
  ) u_por (
    .pclk    (pclk),
    .presetn (presetn),
    .pg      (r.s2[PIN_PG]),
    .done    (por_done)
  );

  rlvd_rst_sync u_sync ( // [R21]
    .pclk      (pclk),
    .presetn   (presetn),
    .rst_req   (r.rst_req),
    .sys_rst_n (sys_rst_n)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic              access;
  logic              hit;
  logic              commit;
  logic [31:0]       rdata;
  logic [1:0]        lvl;
  logic [11:0]       thr_sup;
  logic [11:0]       thr_pin;
  logic [12:0]       rel_sup;
  logic [12:0]       rel_pin;
  logic              gated;
  logic              lvd_evt;
  logic              lvd_rst;
  logic              rtc_evt;
  logic              wdt_evt;
  logic              wake_evt;
  logic              kick;
  logic [PIN_W-1:0]  rise;

  always_comb begin
    n        = r;
    access   = psel & penable;
    hit      = 1'b1;
    rdata    = '0;
    kick     = 1'b0;
    wdt_evt  = 1'b0;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // two-flop pin synchronisers, third stage for edges
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    rise = r.s2 & ~r.s3;

    // ----------------------------------------------------------------
    // register read mux
    // ----------------------------------------------------------------
    case (paddr)
      OFF_LVC:  rdata = {24'h000000, r.lvc};
      OFF_CTRL: rdata = {28'h0000000, r.ctrl};
      OFF_WDT:  rdata = '0;
      OFF_STAT: begin
        rdata                            = '0;
        rdata[STAT_PG]                   = r.s2[PIN_PG];
        rdata[STAT_POR_DONE]             = por_done;
        rdata[STAT_DET_SUP]              = r.det_sup;
        rdata[STAT_DET_PIN]              = r.det_pin;
        rdata[STAT_CAUSE +: CAUSE_W]     = r.cause;
      end
      default:  hit = 1'b0;
    endcase

    // ----------------------------------------------------------------
    // apb response
    // ----------------------------------------------------------------
    // one wait state: answer at the second access edge
    commit = access & r.pready & pwrite & hit & pstrb[0];
    if (access && !r.pready) begin
      n.pready  = 1'b1;
      n.pslverr = ~hit;
      n.prdata  = (hit && !pwrite) ? rdata : '0;
    end else begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (commit) begin
      case (paddr)
        OFF_LVC: begin
          n.lvc[LVC_RST_ALLOW:0] = pwdata[LVC_RST_ALLOW:0];
          if (!pwdata[LVC_PEND]) begin
            n.lvc[LVC_PEND] = 1'b0; // [R10]
          end
        end
        OFF_CTRL: begin
          n.ctrl = pwdata[CTRL_W-1:0];
        end
        OFF_WDT: begin
          kick = pwdata[WDT_KICK]; // [R18]
        end
        OFF_STAT: begin
          n.cause = r.cause & ~pwdata[STAT_CAUSE +: CAUSE_W];
        end
        default:  n.ctrl = r.ctrl;
      endcase
    end

    // ----------------------------------------------------------------
    // voltage detector
    // ----------------------------------------------------------------
    lvl     = r.lvc[LVC_LVL_LSB +: 2]; // [R6]
    thr_sup = SUP_THR_MV[lvl];
    thr_pin = PIN_THR_MV[lvl];
    // release only at or above threshold plus hysteresis
    rel_sup = {1'b0, thr_sup} + {1'b0, HYST_MV}; // [R16]
    rel_pin = {1'b0, thr_pin} + {1'b0, HYST_MV}; // [R16]

    if (r.lvc[LVC_ON_N] || r.lvc[LVC_SUP_N]) begin
      n.det_sup = 1'b0; // [R12] [R15]
    end else if (r.det_sup) begin
      n.det_sup = ({1'b0, regulator_input_supply} < rel_sup);
    end else begin
      n.det_sup = (regulator_input_supply < thr_sup);
    end

    if (r.lvc[LVC_ON_N] || r.lvc[LVC_PIN_N]) begin
      n.det_pin = 1'b0; // [R12] [R14]
    end else if (r.det_pin) begin
      n.det_pin = ({1'b0, pin_voltage} < rel_pin);
    end else begin
      n.det_pin = (pin_voltage < thr_pin);
    end

    // output gate; software keeps it shut while settling
    gated     = ~r.lvc[LVC_GATE_N] & (r.det_sup | r.det_pin); // [R13] [R8] [R9]
    n.gated_d = gated;
    lvd_evt   = gated & ~r.gated_d;
    lvd_rst   = lvd_evt & ~r.ctrl[CTRL_IRQ_EN] & r.lvc[LVC_RST_ALLOW]; // [R7] [R11]
    if (lvd_evt) begin
      n.lvc[LVC_PEND] = 1'b1; // [R10]
    end
    n.irq = n.lvc[LVC_PEND] & r.ctrl[CTRL_IRQ_EN]; // [R7]

    // ----------------------------------------------------------------
    // rtc, wakeup, watchdog
    // ----------------------------------------------------------------
    rtc_evt  = r.ctrl[CTRL_RTC_RST] & (rise[PIN_RTC_SEC] | rise[PIN_RTC_ALM]); // [R17]
    wake_evt = sleep_mode & r.ctrl[CTRL_WAKE_EN] & rise[PIN_WAKE]; // [R19]

    if (!r.ctrl[CTRL_WDT_EN] || kick) begin
      n.wdt_cnt = '0;
    end else if (r.wdt_cnt == WW'(WDT_CYC - 1)) begin
      n.wdt_cnt = '0;
      wdt_evt   = 1'b1; // [R18]
    end else begin
      n.wdt_cnt = r.wdt_cnt + WW'(1);
    end

    // ----------------------------------------------------------------
    // combined reset
    // ----------------------------------------------------------------
    // short events are stretched so the core sees a clean pulse
    if (lvd_rst || rtc_evt || wdt_evt || wake_evt) begin
      n.hold = HW'(HOLD_CYC);
    end else if (r.hold != '0) begin
      n.hold = r.hold - HW'(1);
    end
    // pg loss clears por_done, so a fast cycle gets the full delay
    n.rst_req = ~por_done | (n.hold != '0); // [R1] [R2] [R3] [R5] [R20]

    // ----------------------------------------------------------------
    // reset causes
    // ----------------------------------------------------------------
    // sticky causes; a new cause wins over a clear
    if (!por_done) begin
      n.cause[CAUSE_POR] = 1'b1;
    end
    if (lvd_rst) begin
      n.cause[CAUSE_LVD] = 1'b1;
    end
    if (rtc_evt) begin
      n.cause[CAUSE_RTC] = 1'b1;
    end
    if (wdt_evt) begin
      n.cause[CAUSE_WDT] = 1'b1;
    end
    if (wake_evt) begin
      n.cause[CAUSE_WAKE] = 1'b1;
    end

    // ----------------------------------------------------------------
    // fetch restart
    // ----------------------------------------------------------------
    // fetch restarts at the normal-mode vector
    // next request, not the registered one: restart must not lag the async reset
    n.restart = n.rst_req | ~sys_rst_n; // [R4]
    if (n.restart) begin
      n.fetch = RESET_VECTOR; // [R4]
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= ST_RESET;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // sys_rst_n: async assert, two-stage release [R21]
  assign prdata        = r.prdata;
  assign pready        = r.pready;
  assign pslverr       = r.pslverr;
  assign fetch_restart = r.restart;
  assign fetch_addr    = r.fetch;
  assign undervolt_irq = r.irq;

endmodule // rlvd_top
`default_nettype wire

/* bench/rlvd_props.sv */
`timescale 1ns/1ns
`default_nettype none
module rlvd_props (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // reset path
  input wire logic        power_good_level,
  input wire logic        sys_rst_n,
  input wire logic        fetch_restart,
  input wire logic [15:0] fetch_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fetch_vector: assert property (!sys_rst_n |-> fetch_addr == 16'h8000)
    else $error("fetch address off vector in reset");
  a_restart_level: assert property (!sys_rst_n |-> fetch_restart)
    else $error("restart low during reset");
  a_pg_loss_rst: assert property ($fell(power_good_level) |-> ##[1:6] !sys_rst_n)
    else $error("no reset after power loss");
  a_por_wait: assert property ($rose(sys_rst_n) |-> $past(power_good_level, 20))
    else $error("reset released too soon");
  a_rst_min_hold: assert property ($fell(sys_rst_n) |-> !sys_rst_n [*8])
    else $error("reset pulse too short");
  a_ready_pulse: assert property (pready |=> !pready) // [APB]
    else $error("ready longer than one cycle");
  a_ready_wait: assert property ($rose(penable) && psel |=> pready) // [APB]
    else $error("ready not after one wait state");
  a_err_with_ready: assert property (pslverr |-> pready) // [APB]
    else $error("error without ready");

  cover property ($rose(sys_rst_n));
  cover property ($fell(sys_rst_n));
  cover property (pslverr);
endmodule // rlvd_props

bind rlvd_top rlvd_props rlvd_props_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .power_good_level(power_good_level), .sys_rst_n(sys_rst_n),
  .fetch_restart(fetch_restart), .fetch_addr(fetch_addr));
`default_nettype wire

/* bench/rlvd_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module rlvd_core_model (
  // from reset block
  input  wire logic        pclk,
  input  wire logic        sys_rst_n,
  input  wire logic [15:0] fetch_addr,
  // observed state
  output logic [15:0]      pc,
  output int               rst_cnt
);
  initial rst_cnt = 0;
  always @(negedge sys_rst_n) rst_cnt++;
  always_ff @(posedge pclk) begin
    if (!sys_rst_n) begin
      pc <= fetch_addr;
    end else begin
      pc <= pc + 16'h0001;
    end
  end
endmodule // rlvd_core_model
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rlvd_pkg::*;
  localparam int POR = 20;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, rd_e, sys_rst_n, fetch_restart, undervolt_irq;
  logic        power_good_level = 0, rtc_second = 0, rtc_alarm = 0, port_wake = 0, sleep_mode = 0;
  logic [11:0] regulator_input_supply = 12'hFFF, pin_voltage = 12'hFFF;
  logic [15:0] fetch_addr, pc;
  logic [11:0] thr [4] = '{12'h898, 12'h960, 12'hA8C, 12'hC1C};
  int          rst_cnt, fail_count = 0, comparisons = 0, cyc = 0;

  rlvd_top #(.POR_CYC(POR), .WDT_CYC(50)) rlvd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_good_level(power_good_level), .rtc_second(rtc_second),
    .rtc_alarm(rtc_alarm), .port_wake(port_wake), .sleep_mode(sleep_mode), .pin_voltage(pin_voltage),
    .regulator_input_supply(regulator_input_supply), .sys_rst_n(sys_rst_n), .fetch_restart(fetch_restart),
    .fetch_addr(fetch_addr), .undervolt_irq(undervolt_irq));
  rlvd_core_model rlvd_core_model_i (.pclk(pclk), .sys_rst_n(sys_rst_n), .fetch_addr(fetch_addr),
    .pc(pc), .rst_cnt(rst_cnt));

  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  // waits for pready as long as it takes; only the bench timeout ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check(pready, 1'b1, "no ready"); // [APB]
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    check(rd_q, exp, "read data");
    check(rd_e, e, "slave error"); // [APB]
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // supply change seen on irq a few edges later
  task automatic volt(input logic [11:0] v, input logic e);
    regulator_input_supply <= v;
    wt(6);
    check(undervolt_irq, e, "undervolt irq");
  endtask
  task automatic rst_seen(input logic e);
    logic got;
    got = 0;
    repeat (50) begin
      @(posedge pclk);
      if (sys_rst_n === 1'b0) got = 1;
    end
    check(got, e, "reset source");
    check(sys_rst_n, 1'b1, "reset stuck");
    if (e) check(pc[15:8], 8'h80, "restart address");
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_por();
    int n;
    wt(30);
    check(sys_rst_n, 1'b0, "released unpowered");
    power_good_level <= 1'b1;
    n = 0;
    while (sys_rst_n !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check(n >= POR + 2 && n <= POR + 10, 1'b1, "power-up delay");
  endtask
  task automatic t_regs();
    rd_chk(OFF_LVC, 32'h48, 1'b0);
    rd_chk(OFF_CTRL, 32'h0, 1'b0);
    rd_chk(8'h10, 32'h0, 1'b1);
    rd_chk(OFF_STAT, 32'h103, 1'b0);
    wr(OFF_STAT, 32'h100);
    rd_chk(OFF_STAT, 32'h3, 1'b0);
    wr(OFF_LVC, 32'hC8);
    rd_chk(OFF_LVC, 32'h48, 1'b0);
  endtask
  task automatic t_level(input logic [1:0] l);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_LVC, 32'h78 | l);
    wr(OFF_LVC, 32'h58 | l);
    regulator_input_supply <= thr[l] - 12'h001;
    wt(1000);
    rd_chk(OFF_LVC, 32'h58 | l, 1'b0);
    regulator_input_supply <= 12'hFFF;
    wt(3);
    wr(OFF_LVC, 32'h48 | l);
    volt(thr[l], 1'b0);
    volt(thr[l] - 12'h001, 1'b1);
    rd_chk(OFF_LVC, 32'hC8 | l, 1'b0);
    wr(OFF_LVC, 32'h48 | l);
    volt(thr[l] + 12'h095, 1'b0);
    volt(thr[l] - 12'h001, 1'b0);
    volt(thr[l] + 12'h096, 1'b0);
    volt(thr[l] - 12'h001, 1'b1);
    volt(12'hFFF, 1'b1);
    wr(OFF_LVC, 32'h48 | l);
    wt(1);
    check(undervolt_irq, 1'b0, "irq not cleared");
  endtask
  task automatic t_pin();
    wr(OFF_LVC, 32'h64);
    pin_voltage <= 12'h707;
    volt(12'hFFF, 1'b0);
    wr(OFF_LVC, 32'h54);
    wt(1000);
    wr(OFF_LVC, 32'h44);
    volt(12'hFFF, 1'b1);
    pin_voltage <= 12'hFFF;
    wr(OFF_LVC, 32'h4C);
  endtask
  task automatic t_lvd_rst();
    wr(OFF_CTRL, 32'h0);
    wr(OFF_LVC, 32'h08);
    regulator_input_supply <= 12'h897;
    rst_seen(1'b0);
    regulator_input_supply <= 12'hFFF;
    wr(OFF_LVC, 32'h48);
    regulator_input_supply <= 12'h897;
    rst_seen(1'b1);
    regulator_input_supply <= 12'hFFF;
  endtask
  task automatic t_rtc_wake();
    wr(OFF_CTRL, 32'h0);
    rtc_second <= 1'b1;
    rst_seen(1'b0);
    rtc_second <= 1'b0;
    wr(OFF_CTRL, 32'h2);
    rtc_second <= 1'b1;
    rst_seen(1'b1);
    wr(OFF_CTRL, 32'hA);
    rtc_alarm <= 1'b1;
    rst_seen(1'b1);
    wr(OFF_CTRL, 32'h8);
    port_wake <= 1'b1;
    rst_seen(1'b0);
    port_wake <= 1'b0;
    sleep_mode <= 1'b1;
    wt(4);
    port_wake <= 1'b1;
    rst_seen(1'b1);
    sleep_mode <= 1'b0;
  endtask
  task automatic t_wdt();
    int c;
    c = rst_cnt;
    wr(OFF_CTRL, 32'h4);
    repeat (4) begin
      wt(30);
      wr(OFF_WDT, 32'h20);
    end
    check(rst_cnt, c, "kicked watchdog fired");
    wt(30);
    rst_seen(1'b1);
    wr(OFF_CTRL, 32'h0);
  endtask
  task automatic t_pg();
    power_good_level <= 1'b0;
    wt(48);
    check(sys_rst_n, 1'b0, "no reset on power loss");
    power_good_level <= 1'b1;
    wt(40);
    check(sys_rst_n, 1'b1, "no restart after power return");
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    wt(12);
    presetn <= 1'b1;
    t_por();
    t_regs();
    for (int l = 0; l < 4; l++) t_level(l[1:0]);
    t_pin();
    t_lvd_rst();
    t_rtc_wake();
    t_wdt();
    t_pg();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
